// [can_rx_consts.svh]
`ifndef CAN_RX_CONSTS_SVH
`define CAN_RX_CONSTS_SVH

`define ADR_RX_FIFO_CONTROL    8'h00
`define ADR_RX_OVF_LOW         8'h04
`define ADR_RX_OVF_HIGH        8'h08
`define ADR_BUF_FULL           8'h0C
`define ADR_IRQ_STATUS         8'h10
`define ADR_IRQ_MASK           8'h14

`define NUM_BUFFERS            32
`define BUF_IDX_W              5
`define FLAG_HALF_W            16
`define REG_W                  16

`define CNT_SEL_MSB            15
`define CNT_SEL_LSB            13
`define FIFO_START_MSB         4
`define FIFO_START_LSB         0
`define RX_FIFO_CONTROL_RESET  16'h0000
`define RX_OVF_RESET           16'h0000
`define CNT_SEL_RESERVED       3'h7
`define BUF_COUNT_RESET        6'h04

`define IRQ_W                  2
`define IRQ_BIT_OVERFLOW       0
`define IRQ_BIT_BAD_INDEX      1
`define IRQ_RESET              2'h0

`endif

// [can_rx_pkg.sv]
`include "can_rx_consts.svh"

package can_rx_pkg;

	typedef logic [`BUF_IDX_W-1:0] buf_idx_t;

	typedef struct packed {
		logic     valid;
		buf_idx_t index;
	} store_req_t;

	typedef struct packed {
		logic accepted;
		logic dropped;
	} store_rsp_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

endpackage

// [rx_overflow_flag_bank.sv]
`timescale 1ns/100ps
`default_nettype none

`include "can_rx_consts.svh"

module rx_overflow_flag_bank (
	input  wire logic                     core_clk,
	input  wire logic                     rst_b,
	input  wire logic [`NUM_BUFFERS-1:0]  setFlag,
	input  wire logic [`NUM_BUFFERS-1:0]  writeLane,
	input  wire logic [`NUM_BUFFERS-1:0]  writeData,
	output logic      [`NUM_BUFFERS-1:0]  flags
);
	genvar n;
	generate
		for (n = 0; n < `NUM_BUFFERS; n = n + 1) begin : g_flag
			logic flagQ;
			logic flagD;
			// A hardware set in the same cycle as a software clear keeps the flag.
			assign flagD = setFlag[n] | (flagQ & ~(writeLane[n] & ~writeData[n]));
			always_ff @(posedge core_clk) begin
				if (!rst_b) begin
					flagQ <= 1'b0;
				end else begin
					flagQ <= flagD;
				end
			end
			assign flags[n] = flagQ;
		end
	endgenerate

endmodule

`default_nettype wire

// [can_rx_buffer_fifo_overflow.sv]
// Operation
// - Three-bit count select gives 4,6,8,12,16,24,32 buffers; code 111 reserved.
// - Five-bit FIFO start value names the first FIFO buffer directly.
// - Storing into a still-full buffer sets that buffer's overflow flag.
// - Overflow flags clear only by software writing zero; ones do nothing.
// - Low overflow register bit n is buffer n, buffers 0 to 15.
// - High overflow register bit 0 is buffer 16, bit 15 buffer 31.
`timescale 1ns/100ps
`default_nettype none

`include "can_rx_consts.svh"

module can_rx_buffer_fifo_overflow (
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	input  wire can_rx_pkg::wb_req_t     wbReq,
	output can_rx_pkg::wb_rsp_t          wbRsp,
	input  wire can_rx_pkg::store_req_t  storeReq,
	output can_rx_pkg::store_rsp_t       storeRsp,
	output logic [2:0]                   ramBufferCountSel,
	output logic [5:0]                   ramBufferCount,
	output logic [`BUF_IDX_W-1:0]        fifoStartBuffer,
	output logic [`NUM_BUFFERS-1:0]      bufferFull,
	output logic                         irq
);
	import can_rx_pkg::*;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_t;

	bus_state_t                 busQ;
	bus_state_t                 busD;
	logic [`REG_W-1:0]          controlQ;
	logic [`REG_W-1:0]          controlD;
	logic [`NUM_BUFFERS-1:0]    fullQ;
	logic [`NUM_BUFFERS-1:0]    fullD;
	logic [`IRQ_W-1:0]          irqStatusQ;
	logic [`IRQ_W-1:0]          irqStatusD;
	logic [`IRQ_W-1:0]          irqMaskQ;
	logic [`IRQ_W-1:0]          irqMaskD;
	logic [31:0]                readDataQ;
	store_rsp_t                 storeRspQ;
	store_rsp_t                 storeRspD;
	logic [5:0]                 countQ;
	logic [`NUM_BUFFERS-1:0]    overflowFlags;

	// Bus decode: the write lands at the edge where the master sees ack.
	wire        busReq      = wbReq.cyc & wbReq.stb;
	wire        writeNow    = busReq & wbReq.we & (busQ == BUS_ACK);
	wire        hitControl  = (wbReq.adr == `ADR_RX_FIFO_CONTROL);
	wire        hitOvfLow   = (wbReq.adr == `ADR_RX_OVF_LOW);
	wire        hitOvfHigh  = (wbReq.adr == `ADR_RX_OVF_HIGH);
	wire        hitFull     = (wbReq.adr == `ADR_BUF_FULL);
	wire        hitIrqStat  = (wbReq.adr == `ADR_IRQ_STATUS);
	wire        hitIrqMask  = (wbReq.adr == `ADR_IRQ_MASK);
	wire [31:0] laneMask    = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}},
	                           {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
	wire [31:0] maskedData  = wbReq.dat & laneMask;
	wire [31:0] writeBits   = wbReq.dat;

	// Overflow register lanes: low word covers buffers 0-15, high word 16-31.
	wire [`NUM_BUFFERS-1:0] ovfLane = {
		(writeNow & hitOvfHigh) ? laneMask[`FLAG_HALF_W-1:0] : `RX_OVF_RESET,
		(writeNow & hitOvfLow)  ? laneMask[`FLAG_HALF_W-1:0] : `RX_OVF_RESET};
	wire [`NUM_BUFFERS-1:0] ovfData = {writeBits[`FLAG_HALF_W-1:0],
	                                    writeBits[`FLAG_HALF_W-1:0]};

	// Store path: a buffer beyond the configured count has no RAM behind it.
	wire        storeInRange = ({1'b0, storeReq.index} < countQ);
	wire        targetFull   = fullQ[storeReq.index];
	wire        storeOverflow = storeReq.valid & storeInRange & targetFull;
	wire        storeAccept  = storeReq.valid & storeInRange & ~targetFull;
	wire        storeBad     = storeReq.valid & ~storeInRange;
	wire [`NUM_BUFFERS-1:0] indexOneHot  = `NUM_BUFFERS'(1) << storeReq.index;
	wire [`NUM_BUFFERS-1:0] overflowSet  = storeOverflow ? indexOneHot : '0;
	wire [`NUM_BUFFERS-1:0] acceptSet    = storeAccept ? indexOneHot : '0;

	function automatic logic [5:0] decode_count(input logic [2:0] code);
		unique case (code)
			3'h0: decode_count = 6'h04;
			3'h1: decode_count = 6'h06;
			3'h2: decode_count = 6'h08;
			3'h3: decode_count = 6'h0C;
			3'h4: decode_count = 6'h10;
			3'h5: decode_count = 6'h18;
			3'h6: decode_count = 6'h20;
			default: decode_count = 6'h04;
		endcase
	endfunction

	wire [2:0] newCountSel = maskedData[`CNT_SEL_MSB:`CNT_SEL_LSB] |
		(controlQ[`CNT_SEL_MSB:`CNT_SEL_LSB] & ~laneMask[`CNT_SEL_MSB:`CNT_SEL_LSB]);
	// The reserved count code is refused; the field keeps its old value.
	wire [2:0] keptCountSel = (newCountSel == `CNT_SEL_RESERVED) ?
		controlQ[`CNT_SEL_MSB:`CNT_SEL_LSB] : newCountSel;
	wire [`BUF_IDX_W-1:0] newFifoStart = maskedData[`FIFO_START_MSB:`FIFO_START_LSB] |
		(controlQ[`FIFO_START_MSB:`FIFO_START_LSB] &
		 ~laneMask[`FIFO_START_MSB:`FIFO_START_LSB]);
	wire [`REG_W-1:0] controlWritten = {keptCountSel, 8'h00, newFifoStart};

	always_comb begin
		controlD = controlQ;
		if (writeNow && hitControl) begin
			controlD = controlWritten;
		end
	end

	// Software frees a buffer by writing one to its full bit; a store to it in that cycle still sees it full.
	wire [`NUM_BUFFERS-1:0] releaseBits = (writeNow & hitFull) ? maskedData : '0;
	assign fullD = acceptSet | (fullQ & ~releaseBits);

	wire [`IRQ_W-1:0] irqEvents;
	assign irqEvents[`IRQ_BIT_OVERFLOW]  = storeOverflow;
	assign irqEvents[`IRQ_BIT_BAD_INDEX] = storeBad;
	wire [`IRQ_W-1:0] irqClear = (writeNow & hitIrqStat) ? maskedData[`IRQ_W-1:0] : '0;
	assign irqStatusD = irqEvents | (irqStatusQ & ~irqClear);
	assign irqMaskD   = (writeNow & hitIrqMask) ? (maskedData[`IRQ_W-1:0] |
		(irqMaskQ & ~laneMask[`IRQ_W-1:0])) : irqMaskQ;

	assign storeRspD.accepted = storeAccept;
	assign storeRspD.dropped  = storeOverflow | storeBad;

	always_comb begin
		busD = busQ;
		unique case (busQ)
			BUS_IDLE: begin
				if (busReq) begin
					busD = BUS_ACK;
				end
			end
			BUS_ACK: begin
				busD = BUS_IDLE;
			end
			default: begin
				busD = BUS_IDLE;
			end
		endcase
	end

	// Unmapped addresses answer with ack and read as zero.
	wire [31:0] readMux =
		hitControl ? {16'h0000, controlQ} :
		hitOvfLow  ? {16'h0000, overflowFlags[`FLAG_HALF_W-1:0]} :
		hitOvfHigh ? {16'h0000, overflowFlags[`NUM_BUFFERS-1:`FLAG_HALF_W]} :
		hitFull    ? fullQ :
		hitIrqStat ? {30'h0, irqStatusQ} :
		hitIrqMask ? {30'h0, irqMaskQ} : 32'h00000000;

	rx_overflow_flag_bank u_flags (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.setFlag   (overflowSet),
		.writeLane (ovfLane),
		.writeData (ovfData),
		.flags     (overflowFlags)
	);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			busQ       <= BUS_IDLE;
			controlQ   <= `RX_FIFO_CONTROL_RESET;
			fullQ      <= '0;
			irqStatusQ <= `IRQ_RESET;
			irqMaskQ   <= `IRQ_RESET;
			readDataQ  <= 32'h00000000;
			storeRspQ  <= '0;
			countQ     <= `BUF_COUNT_RESET;
		end else begin
			busQ       <= busD;
			controlQ   <= controlD;
			fullQ      <= fullD;
			irqStatusQ <= irqStatusD;
			irqMaskQ   <= irqMaskD;
			readDataQ  <= readMux;
			storeRspQ  <= storeRspD;
			countQ     <= decode_count(controlD[`CNT_SEL_MSB:`CNT_SEL_LSB]);
		end
	end

	assign wbRsp.ack         = (busQ == BUS_ACK) & busReq;
	assign wbRsp.dat         = readDataQ;
	assign storeRsp          = storeRspQ;
	assign ramBufferCountSel = controlQ[`CNT_SEL_MSB:`CNT_SEL_LSB];
	assign ramBufferCount    = countQ;
	assign fifoStartBuffer   = controlQ[`FIFO_START_MSB:`FIFO_START_LSB];
	assign bufferFull        = fullQ;
	assign irq               = |(irqStatusQ & irqMaskQ);

endmodule

`default_nettype wire

// [msg_source.sv]
`timescale 1ns/100ps
`default_nettype none
module msg_source (
	input  wire logic                   core_clk,
	input  wire logic                   rst_b,
	input  wire logic                   fire,
	input  wire can_rx_pkg::buf_idx_t   idx,
	output can_rx_pkg::store_req_t      storeReq
);
	import can_rx_pkg::*;
	// Between messages the index toggles so a stale value never looks valid.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			storeReq <= '0;
		end else begin
			storeReq.valid <= fire;
			storeReq.index <= fire ? idx : ~storeReq.index;
		end
	end
endmodule
`default_nettype wire

// [can_rx_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
`include "can_rx_consts.svh"
module can_rx_assertions (
	input wire logic                     core_clk,
	input wire logic                     rst_b,
	input wire can_rx_pkg::wb_req_t      wbReq,
	input wire can_rx_pkg::wb_rsp_t      wbRsp,
	input wire can_rx_pkg::store_req_t   storeReq,
	input wire can_rx_pkg::store_rsp_t   storeRsp,
	input wire logic [2:0]               ramBufferCountSel,
	input wire logic [5:0]               ramBufferCount,
	input wire logic [`BUF_IDX_W-1:0]    fifoStartBuffer,
	input wire logic [`NUM_BUFFERS-1:0]  bufferFull,
	input wire logic                     irq
);
	import can_rx_pkg::*;
	localparam logic [5:0] COUNTS [8] = '{6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20, 6'h04};
	wire busWr = wbRsp.ack && wbReq.we;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	ack_wait_a: assert property ($rose(wbReq.stb) |-> !wbRsp.ack ##1 wbRsp.ack)
		else $error("Ack not after one wait state.");
	ack_pulse_a: assert property (wbRsp.ack |-> wbReq.cyc && wbReq.stb ##1 !wbRsp.ack)
		else $error("Ack not a single cycle.");
	store_rsp_a: assert property (storeReq.valid |=> storeRsp.accepted != storeRsp.dropped)
		else $error("Store got no single answer.");
	full_drop_a: assert property (storeReq.valid && bufferFull[storeReq.index] && !busWr
		|=> storeRsp.dropped)
		else $error("Store into full buffer not dropped.");
	acc_mark_a: assert property (storeRsp.accepted |-> bufferFull[$past(storeReq.index)])
		else $error("Accepted buffer not marked full.");
	drop_keep_a: assert property (storeRsp.dropped && !$past(busWr) |-> $stable(bufferFull))
		else $error("Dropped store changed full state.");
	bad_idx_a: assert property (storeReq.valid && {1'b0, storeReq.index} >= ramBufferCount
		|=> storeRsp.dropped)
		else $error("Out of range store not dropped.");
	cnt_map_a: assert property (ramBufferCount == COUNTS[ramBufferCountSel])
		else $error("Buffer count decode wrong.");
	no_rsv_a: assert property (ramBufferCountSel != 3'h7)
		else $error("Reserved count code stored.");
	acc_c: cover property (storeRsp.accepted);
	drop_c: cover property (storeRsp.dropped);
	irq_c: cover property ($rose(irq));
endmodule
bind can_rx_buffer_fifo_overflow can_rx_assertions chk (.core_clk(core_clk), .rst_b(rst_b),
	.wbReq(wbReq), .wbRsp(wbRsp), .storeReq(storeReq), .storeRsp(storeRsp),
	.ramBufferCountSel(ramBufferCountSel), .ramBufferCount(ramBufferCount),
	.fifoStartBuffer(fifoStartBuffer), .bufferFull(bufferFull), .irq(irq));
`default_nettype wire

// [tb_can_rx_buffer_fifo_overflow.sv]
`timescale 1ns/100ps
`default_nettype none
`include "can_rx_consts.svh"
module tb_can_rx_buffer_fifo_overflow;
	import can_rx_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        fire = 1'b0;
	buf_idx_t    idx = '0;
	wb_req_t     wbReq = '0;
	wb_rsp_t     wbRsp;
	store_req_t  storeReq;
	store_rsp_t  storeRsp;
	logic [2:0]  cSel;
	logic [5:0]  cnt;
	buf_idx_t    fStart;
	logic [31:0] full;
	logic        irq;
	logic [31:0] rd;
	logic        acc;
	logic        drp;
	int          errTotal = 0;
	int          compares = 0;
	always #50 core_clk = ~core_clk;
	can_rx_buffer_fifo_overflow uut (.core_clk(core_clk), .rst_b(rst_b), .wbReq(wbReq),
		.wbRsp(wbRsp), .storeReq(storeReq), .storeRsp(storeRsp), .ramBufferCountSel(cSel),
		.ramBufferCount(cnt), .fifoStartBuffer(fStart), .bufferFull(full), .irq(irq));
	msg_source src (.core_clk(core_clk), .rst_b(rst_b), .fire(fire), .idx(idx),
		.storeReq(storeReq));
	function automatic logic [31:0] expCnt(input logic [2:0] s);
		logic [5:0] t [8] = '{6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20, 6'h04};
		return {26'h0, t[s]};
	endfunction
	task automatic stopTest();
		$display("Compares %0d mismatches %0d", compares, errTotal);
		if (errTotal == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errTotal++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		wbReq <= '{1'b1, 1'b1, w, a, 4'hF, d};
		do begin
			@(posedge core_clk);
			n++;
		end while (wbRsp.ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk(1'b0, 1'b1);
			stopTest();
		end
		rd = wbRsp.dat;
		wbReq <= '0;
	endtask
	task automatic st(input buf_idx_t k);
		@(posedge core_clk);
		fire <= 1'b1;
		idx <= k;
		@(posedge core_clk);
		fire <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		acc = storeRsp.accepted;
		drp = storeRsp.dropped;
	endtask
	initial begin
		logic [2:0] es;
		logic [4:0] fs;
		logic [7:0] a;
		int k;
		int ks [4] = '{0, 15, 16, 31};
		void'($urandom(32'hCA4B));
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int r = 0; r < 3; r++) begin
			wb(1'b0, 8'(4 * r), 32'h0);
			chk(rd, 32'h0);
		end
		chk(cnt, 32'h4);
		$display("Reset test done");
		for (int s = 0; s < 8; s++) begin
			es = (s == 7) ? 3'h6 : 3'(s);
			fs = s[0] ? 5'h1F : 5'h1E;
			wb(1'b1, `ADR_RX_FIFO_CONTROL, {16'h0, 3'(s), 8'h00, fs});
			wb(1'b0, `ADR_RX_FIFO_CONTROL, 32'h0);
			chk(rd, {16'h0, es, 8'h00, fs});
			chk(fStart, fs);
			chk(cSel, es);
			chk(cnt, expCnt(es));
		end
		$display("Control test done");
		for (int i = 0; i < 8; i++) begin
			k = (i < 4) ? ks[i] : $urandom_range(31);
			a = (k < 16) ? `ADR_RX_OVF_LOW : `ADR_RX_OVF_HIGH;
			st(5'(k));
			chk(acc, 1'b1);
			chk(full, 32'h1 << k);
			st(5'(k));
			chk(drp, 1'b1);
			chk(full, 32'h1 << k);
			wb(1'b0, a, 32'h0);
			chk(rd, 32'h1 << k[3:0]);
			wb(1'b1, a, 32'hFFFF);
			wb(1'b0, a, 32'h0);
			chk(rd, 32'h1 << k[3:0]);
			wb(1'b1, a, ~(32'h1 << k[3:0]));
			wb(1'b0, a, 32'h0);
			chk(rd, 32'h0);
			wb(1'b1, `ADR_BUF_FULL, 32'h1 << k);
		end
		$display("Overflow test done");
		wb(1'b1, `ADR_RX_FIFO_CONTROL, 32'h0);
		st(5'h04);
		chk(drp, 1'b1);
		wb(1'b0, `ADR_RX_OVF_LOW, 32'h0);
		chk(rd, 32'h0);
		chk(irq, 1'b0);
		wb(1'b1, `ADR_IRQ_MASK, 32'h3);
		@(negedge core_clk);
		chk(irq, 1'b1);
		wb(1'b0, `ADR_IRQ_STATUS, 32'h0);
		chk(rd, 32'h3);
		wb(1'b1, `ADR_IRQ_STATUS, 32'h3);
		@(negedge core_clk);
		chk(irq, 1'b0);
		wb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		$display("Interrupt test done");
		stopTest();
	end
endmodule
`default_nettype wire
